// file: core/jpc_pkg.sv
// Constants and types shared by the scan pin mode and probe controller
package jpc_pkg;

  // ==========================================================
  // Pin and synchroniser bit positions
  localparam int PIN_TDI = 0;
  localparam int PIN_TCK = 1;
  localparam int PIN_TDO = 2;
  localparam int SB_TMS  = 3;
  localparam int SB_PROG = 4;
  localparam int SB_SEC  = 5;
  localparam int SYNC_W  = 6;

  // ==========================================================
  // Scan controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jpc_tap_e;

  localparam int TAP_RELEASE_STAGES = 2;
  localparam int RESET_TMS_CYCLES   = 5;

  // ==========================================================
  // Instruction register
  localparam int             IR_W       = 4;
  localparam logic [IR_W-1:0] IR_BYPASS  = 4'hF;
  localparam logic [IR_W-1:0] IR_PROBE   = 4'h1;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  // ==========================================================
  // Register map
  localparam int          PADDR_W     = 12;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_PROBE  = 12'h008;

  localparam int   CTRL_PROBE_EN     = 0;
  localparam logic CTRL_PROBE_EN_RST = 1'b1;

  localparam int ST_DEDICATED = 0;
  localparam int ST_CAPTURED  = 1;
  localparam int ST_SECURED   = 2;
  localparam int ST_TAP_LSB   = 4;
  localparam int ST_IR_LSB    = 8;

endpackage

// file: core/jpc_scan_if.sv
// Link between the pin controller and its scan state machine
`timescale 1ns/100ps
`default_nettype none

interface jpc_scan_if;
  logic              advance;
  logic              tms;
  jpc_pkg::jpc_tap_e state;

  modport ctrl (output advance, output tms, input state);
  modport tap  (input advance, input tms, output state);
endinterface

`default_nettype wire

// file: core/jpc_tap.sv
// Sixteen-state scan controller with asynchronous scan reset
`timescale 1ns/100ps
`default_nettype none

module jpc_tap (
  input  wire logic clk,
  input  wire logic arst,
  jpc_scan_if.tap   bus
);

  typedef struct packed {
    jpc_pkg::jpc_tap_e                           state;
    logic [jpc_pkg::TAP_RELEASE_STAGES-1:0]      rel;
    logic [2:0]                                  hi_cnt;
  } jpc_tap_s;

  jpc_tap_s r;
  jpc_tap_s next_r;

  // ==========================================================
  // Transition table
  function automatic jpc_pkg::jpc_tap_e tap_next(
    input jpc_pkg::jpc_tap_e s,
    input logic              m
  );
    case (s)
      jpc_pkg::TAP_RESET:    tap_next = m ? jpc_pkg::TAP_RESET
                                          : jpc_pkg::TAP_IDLE;
      jpc_pkg::TAP_IDLE:     tap_next = m ? jpc_pkg::TAP_SEL_DR
                                          : jpc_pkg::TAP_IDLE;
      jpc_pkg::TAP_SEL_DR:   tap_next = m ? jpc_pkg::TAP_SEL_IR
                                          : jpc_pkg::TAP_CAP_DR;
      jpc_pkg::TAP_CAP_DR:   tap_next = m ? jpc_pkg::TAP_EXIT1_DR
                                          : jpc_pkg::TAP_SHIFT_DR;
      jpc_pkg::TAP_SHIFT_DR: tap_next = m ? jpc_pkg::TAP_EXIT1_DR
                                          : jpc_pkg::TAP_SHIFT_DR;
      jpc_pkg::TAP_EXIT1_DR: tap_next = m ? jpc_pkg::TAP_UPD_DR
                                          : jpc_pkg::TAP_PAUSE_DR;
      jpc_pkg::TAP_PAUSE_DR: tap_next = m ? jpc_pkg::TAP_EXIT2_DR
                                          : jpc_pkg::TAP_PAUSE_DR;
      jpc_pkg::TAP_EXIT2_DR: tap_next = m ? jpc_pkg::TAP_UPD_DR
                                          : jpc_pkg::TAP_SHIFT_DR;
      jpc_pkg::TAP_UPD_DR:   tap_next = m ? jpc_pkg::TAP_SEL_DR
                                          : jpc_pkg::TAP_IDLE;
      jpc_pkg::TAP_SEL_IR:   tap_next = m ? jpc_pkg::TAP_RESET
                                          : jpc_pkg::TAP_CAP_IR;
      jpc_pkg::TAP_CAP_IR:   tap_next = m ? jpc_pkg::TAP_EXIT1_IR
                                          : jpc_pkg::TAP_SHIFT_IR;
      jpc_pkg::TAP_SHIFT_IR: tap_next = m ? jpc_pkg::TAP_EXIT1_IR
                                          : jpc_pkg::TAP_SHIFT_IR;
      jpc_pkg::TAP_EXIT1_IR: tap_next = m ? jpc_pkg::TAP_UPD_IR
                                          : jpc_pkg::TAP_PAUSE_IR;
      jpc_pkg::TAP_PAUSE_IR: tap_next = m ? jpc_pkg::TAP_EXIT2_IR
                                          : jpc_pkg::TAP_PAUSE_IR;
      jpc_pkg::TAP_EXIT2_IR: tap_next = m ? jpc_pkg::TAP_UPD_IR
                                          : jpc_pkg::TAP_SHIFT_IR;
      jpc_pkg::TAP_UPD_IR:   tap_next = m ? jpc_pkg::TAP_SEL_DR
                                          : jpc_pkg::TAP_IDLE;
      default:               tap_next = jpc_pkg::TAP_RESET;
    endcase
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    next_r     = r;
    // Release shifts in ones so a reset edge near CLK cannot split state
    next_r.rel = {r.rel[jpc_pkg::TAP_RELEASE_STAGES-2:0], 1'b1};
    if (bus.advance && r.rel[jpc_pkg::TAP_RELEASE_STAGES-1]) begin
      next_r.state = tap_next(r.state, bus.tms);
      if (!bus.tms) begin
        next_r.hi_cnt = 3'h0;
      end else if (r.hi_cnt != 3'h7) begin
        next_r.hi_cnt = r.hi_cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      r <= '{jpc_pkg::TAP_RESET, '0, 3'h0};
    end else begin
      r <= next_r;
    end
  end

  assign bus.state = r.state;

  // ==========================================================
  // Checks
  held_in_reset_a: assert property (@(posedge clk) disable iff (arst)
    !r.rel[jpc_pkg::TAP_RELEASE_STAGES-1] |-> r.state == jpc_pkg::TAP_RESET)
    else $error("scan state left reset before release");
  five_high_a: assert property (@(posedge clk) disable iff (arst)
    r.hi_cnt >= 3'(jpc_pkg::RESET_TMS_CYCLES)
      |-> r.state == jpc_pkg::TAP_RESET)
    else $error("five TMS-high clocks did not reach logic reset");
  reset_stays_a: assert property (@(posedge clk) disable iff (arst)
    r.state == jpc_pkg::TAP_RESET && bus.advance && bus.tms
      && r.rel[jpc_pkg::TAP_RELEASE_STAGES-1] |=> r.state == jpc_pkg::TAP_RESET)
    else $error("logic reset left with TMS high");

endmodule

`default_nettype wire

// file: core/jpc_port_ctrl.sv
// Scan pin mode control, probe routing and APB status slave
`timescale 1ns/100ps
`default_nettype none

module jpc_port_ctrl #(
  parameter int NETS  = 16,
  parameter int SEL_W = $clog2(NETS)
) (
  input  wire logic                        CLK,
  input  wire logic                        RST,
  input  wire logic                        TRST_N,
  input  wire logic                        TMS,
  input  wire logic                        PROG_FUSE,
  input  wire logic                        SEC_FUSE,
  input  wire logic [2:0]                  PIN_I,
  output var  logic [2:0]                  PIN_O,
  output var  logic [2:0]                  PIN_OE,
  input  wire logic [2:0]                  USER_O,
  input  wire logic [2:0]                  USER_OE,
  output var  logic [2:0]                  USER_I,
  input  wire logic [NETS-1:0]             PROBE_NETS,
  output var  logic                        PROBE_OUT_A,
  output var  logic                        PROBE_OUT_B,
  output var  logic                        TRST_PU,
  output var  logic                        TMS_PU,
  output var  logic                        TDI_PU,
  output var  logic                        TEST_ACTIVE,
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [jpc_pkg::PADDR_W-1:0] PADDR,
  input  wire logic [31:0]                 PWDATA,
  output var  logic                        PREADY,
  output var  logic [31:0]                 PRDATA,
  output var  logic                        PSLVERR
);

  localparam int DR_W = 2 * SEL_W;

  typedef struct packed {
    logic [jpc_pkg::SYNC_W-1:0] s1;
    logic [jpc_pkg::SYNC_W-1:0] s2;
    logic                       tck_q;
    logic                       captured;
    logic [jpc_pkg::IR_W-1:0]   ir;
    logic [jpc_pkg::IR_W-1:0]   ir_sh;
    logic [DR_W-1:0]            dr_sh;
    logic                       bypass;
    logic                       tdo;
    logic [DR_W-1:0]            probe_sel;
    logic                       probe_en;
    logic [2:0]                 pin_o;
    logic [2:0]                 pin_oe;
    logic [2:0]                 user_i;
    logic                       pa;
    logic                       pb;
    logic                       trst_pu;
    logic                       tms_pu;
    logic                       tdi_pu;
    logic                       test_active;
    logic                       pready;
    logic [31:0]                prdata;
    logic                       pslverr;
  } jpc_state_s;

  jpc_state_s r;
  jpc_state_s next_r;

  // ==========================================================
  // Scan state machine
  jpc_scan_if scan ();

  // Scan reset acts straight from the pin, so it needs no TCK or CLK
  logic scan_arst;
  assign scan_arst = RST | ~TRST_N;

  jpc_tap u_tap (
    .clk  (CLK),
    .arst (scan_arst),
    .bus  (scan.tap)
  );

  // ==========================================================
  // Derived pin conditions
  logic tck;
  logic tms;
  logic tdi;
  logic tck_rise;
  logic tck_fall;
  logic dedicated;
  logic secured;
  logic test_act;
  logic capture_evt;
  logic at_reset;
  logic sel_probe;

  assign tck         = r.s2[jpc_pkg::PIN_TCK];
  assign tms         = r.s2[jpc_pkg::SB_TMS];
  assign tdi         = r.s2[jpc_pkg::PIN_TDI];
  assign tck_rise    = tck & ~r.tck_q;
  assign tck_fall    = ~tck & r.tck_q;
  assign dedicated   = r.s2[jpc_pkg::SB_PROG];
  assign secured     = r.s2[jpc_pkg::SB_SEC];
  assign test_act    = dedicated | r.captured;
  assign capture_evt = ~dedicated & ~r.captured & tck_rise & ~tms;
  assign at_reset    = scan.state == jpc_pkg::TAP_RESET;
  assign sel_probe   = r.ir == jpc_pkg::IR_PROBE;

  // In flexible mode TCK edges reach the machine from the capturing edge on
  assign scan.advance = tck_rise & (test_act | capture_evt);
  assign scan.tms     = tms;

  // ==========================================================
  // Next state
  always_comb begin
    next_r       = r;
    next_r.s1    = {SEC_FUSE, PROG_FUSE, TMS, PIN_I};
    next_r.s2    = r.s1;
    next_r.tck_q = tck;

    // Capture wins over release in the same cycle
    next_r.captured = capture_evt
                    | (r.captured & ~at_reset & ~dedicated);

    if (test_act && tck_rise) begin
      case (scan.state)
        jpc_pkg::TAP_CAP_IR:   next_r.ir_sh = jpc_pkg::IR_CAPTURE;
        jpc_pkg::TAP_SHIFT_IR: next_r.ir_sh = {tdi, r.ir_sh[jpc_pkg::IR_W-1:1]};
        jpc_pkg::TAP_CAP_DR: begin
          next_r.dr_sh  = r.probe_sel;
          next_r.bypass = 1'b0;
        end
        jpc_pkg::TAP_SHIFT_DR: begin
          if (sel_probe) begin
            next_r.dr_sh = {tdi, r.dr_sh[DR_W-1:1]};
          end else begin
            next_r.bypass = tdi;
          end
        end
        default: begin
        end
      endcase
    end

    if (test_act && tck_fall) begin
      case (scan.state)
        jpc_pkg::TAP_SHIFT_IR: next_r.tdo = r.ir_sh[0];
        jpc_pkg::TAP_SHIFT_DR: next_r.tdo = sel_probe ? r.dr_sh[0] : r.bypass;
        jpc_pkg::TAP_UPD_IR:   next_r.ir = r.ir_sh;
        jpc_pkg::TAP_UPD_DR: begin
          if (sel_probe) begin
            next_r.probe_sel = r.dr_sh;
          end
        end
        default: begin
        end
      endcase
    end
    if (at_reset) begin
      next_r.ir = jpc_pkg::IR_BYPASS;
    end

    // Pin ownership
    if (test_act) begin
      next_r.pin_o  = {r.tdo, 2'b00};
      next_r.pin_oe = '0;
      next_r.pin_oe[jpc_pkg::PIN_TDO] = scan.state == jpc_pkg::TAP_SHIFT_IR
                                     || scan.state == jpc_pkg::TAP_SHIFT_DR;
      next_r.user_i = '0;
    end else begin
      next_r.pin_o  = USER_O;
      next_r.pin_oe = USER_OE;
      next_r.user_i = r.s2[2:0];
    end
    next_r.test_active = test_act;

    // TMS and TDI pull-ups follow the fuse-selected mode; TRST pull-up is always on
    next_r.trst_pu = 1'b1;
    next_r.tms_pu  = dedicated;
    next_r.tdi_pu  = dedicated;

    // Probe routing; a secured part never shows internal nets
    if (!secured && r.probe_en) begin
      next_r.pa = PROBE_NETS[r.probe_sel[SEL_W-1:0]];
      next_r.pb = PROBE_NETS[r.probe_sel[DR_W-1:SEL_W]];
    end else begin
      next_r.pa = 1'b0;
      next_r.pb = 1'b0;
    end

    // APB slave: answers one cycle into the access phase
    next_r.pready  = 1'b0;
    next_r.pslverr = 1'b0;
    if (PSEL && PENABLE && !r.pready) begin
      next_r.pready = 1'b1;
      next_r.prdata = 32'h0000_0000;
      case (PADDR)
        jpc_pkg::ADDR_CTRL: begin
          if (PWRITE) begin
            next_r.probe_en = PWDATA[jpc_pkg::CTRL_PROBE_EN];
          end else begin
            next_r.prdata[jpc_pkg::CTRL_PROBE_EN] = r.probe_en;
          end
        end
        jpc_pkg::ADDR_STATUS: begin
          if (!PWRITE) begin
            next_r.prdata[jpc_pkg::ST_DEDICATED] = dedicated;
            next_r.prdata[jpc_pkg::ST_CAPTURED]  = r.captured;
            next_r.prdata[jpc_pkg::ST_SECURED]   = secured;
            next_r.prdata[jpc_pkg::ST_TAP_LSB +: 4] = scan.state;
            next_r.prdata[jpc_pkg::ST_IR_LSB +: jpc_pkg::IR_W] = r.ir;
          end
        end
        jpc_pkg::ADDR_PROBE: begin
          if (!PWRITE) begin
            next_r.prdata[DR_W-1:0] = r.probe_sel;
          end
        end
        default: next_r.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r          <= '0;
      r.ir       <= jpc_pkg::IR_BYPASS;
      r.probe_en <= jpc_pkg::CTRL_PROBE_EN_RST;
      r.trst_pu  <= 1'b1;
      // Idle-high TCK must not look like a rising edge after reset
      r.s1[jpc_pkg::PIN_TCK] <= 1'b1;
      r.s2[jpc_pkg::PIN_TCK] <= 1'b1;
      r.tck_q                <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign PIN_O       = r.pin_o;
  assign PIN_OE      = r.pin_oe;
  assign USER_I      = r.user_i;
  assign PROBE_OUT_A = r.pa;
  assign PROBE_OUT_B = r.pb;
  assign TRST_PU     = r.trst_pu;
  assign TMS_PU      = r.tms_pu;
  assign TDI_PU      = r.tdi_pu;
  assign TEST_ACTIVE = r.test_active;
  assign PREADY      = r.pready;
  assign PRDATA      = r.prdata;
  assign PSLVERR     = r.pslverr;

  // ==========================================================
  // Checks
  logic [SEL_W-1:0] sel_a_w;
  logic [SEL_W-1:0] sel_b_w;
  assign sel_a_w = r.probe_sel[SEL_W-1:0];
  assign sel_b_w = r.probe_sel[DR_W-1:SEL_W];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  capture_takes_a: assert property (
    capture_evt |=> r.captured ##1 TEST_ACTIVE && USER_I == 3'h0)
    else $error("TCK rise with TMS low did not capture the pins");
  release_pins_a: assert property (
    r.captured && at_reset && !capture_evt |=> !r.captured ##1 !TEST_ACTIVE)
    else $error("pins not released at logic reset");
  dedicated_pins_a: assert property (
    dedicated |=> TEST_ACTIVE && USER_I == 3'h0 && PIN_OE[1:0] == 2'b00)
    else $error("dedicated mode let pins act as user I/O");
  flexible_user_a: assert property (
    !test_act && !capture_evt |=> PIN_OE == $past(USER_OE)
      && PIN_O == $past(USER_O))
    else $error("flexible idle pins do not follow user logic");
  pullup_mode_a: assert property (
    1'b1 |=> TMS_PU == $past(dedicated) && TDI_PU == $past(dedicated))
    else $error("TMS or TDI pull-up does not match mode");
  trst_pullup_a: assert property (
    1'b1 |-> TRST_PU)
    else $error("TRST pull-up dropped");
  probe_route_a: assert property (
    !secured && r.probe_en |=> PROBE_OUT_A == $past(PROBE_NETS[sel_a_w])
      && PROBE_OUT_B == $past(PROBE_NETS[sel_b_w]))
    else $error("probe outputs do not show selected nets");
  probe_secure_a: assert property (
    secured |=> !PROBE_OUT_A && !PROBE_OUT_B)
    else $error("probe active on a secured part");
  tdo_shift_a: assert property (
    test_act && scan.state == jpc_pkg::TAP_SHIFT_DR |=> PIN_OE[2])
    else $error("TDO not driven while shifting");
  apb_answer_a: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
    else $error("APB answer not exactly one cycle");

  capture_c: cover property (capture_evt ##[1:1000] r.captured && at_reset);
  probe_upd_c: cover property (
    test_act && tck_fall && scan.state == jpc_pkg::TAP_UPD_DR && sel_probe);
  apb_write_c: cover property (PSEL && PENABLE && PWRITE && PREADY);
  dedicated_c: cover property (dedicated && scan.state == jpc_pkg::TAP_SHIFT_IR);

endmodule

`default_nettype wire

// file: test/jpc_tester.sv
// Behavioural scan tester driving the link clock, mode select and data
`timescale 1ns/100ps
`default_nettype none

module jpc_tester (
  input  wire logic clk,
  input  wire logic tdo,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi
);
  // ==========================================================
  // Eight system clocks a half period plus one to start each step give the 170 ns link clock
  localparam int HALF = 8;
  logic          tdo_seen;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    tdo_seen = 1'b0;
  end

  // ==========================================================
  // One link clock; it stays high between frames
  task automatic step(input logic m, input logic d);
    @(posedge clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (HALF) @(posedge clk);
    tck <= 1'b1;
    tdo_seen <= tdo;
    repeat (HALF) @(posedge clk);
  endtask

  task automatic capture();
    step(1'b0, 1'b0);
  endtask

  task automatic release_pins();
    repeat (5) step(1'b1, 1'b0);
  endtask

  task automatic to_shift_ir();
    step(1'b1, 1'b0);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
  endtask

  // LSB first, mode select high on the last bit leaves shift
  task automatic shift4(input logic [3:0] v);
    for (int i = 0; i < 4; i++) step(i == 3, v[i]);
  endtask

  task automatic shift8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) step(i == 7, v[i]);
  endtask
endmodule

`default_nettype wire

// file: test/test_jpc_port_ctrl.sv
// Self-checking bench for the scan pin mode and probe controller
`timescale 1ns/100ps
`default_nettype none

module test_jpc_port_ctrl;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        TRST_N = 1'b1;
  logic        PROG_FUSE = 1'b0;
  logic        SEC_FUSE = 1'b0;
  logic [2:0]  USER_O = 3'h0;
  logic [2:0]  USER_OE = 3'h0;
  logic [15:0] PROBE_NETS = 16'h0000;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [2:0]  PIN_O, PIN_OE, USER_I, pad;
  logic        PROBE_OUT_A, PROBE_OUT_B, TRST_PU, TMS_PU, TDI_PU;
  logic        TEST_ACTIVE, PREADY, PSLVERR;
  logic [31:0] PRDATA;
  logic        tck, tms, tdi;
  logic        tdo_last = 1'b0;
  int          errors = 0;
  int          cmp_count = 0;

  always #5 CLK = ~CLK;

  // ==========================================================
  // Pads: a released TDO line shows the inverse of its last driven value
  always @(posedge CLK) if (PIN_OE[2]) tdo_last <= PIN_O[2];
  assign pad = {PIN_OE[2] ? PIN_O[2] : ~tdo_last,
                PIN_OE[1] ? PIN_O[1] : tck,
                PIN_OE[0] ? PIN_O[0] : tdi};

  jpc_port_ctrl u_jpc_port_ctrl (
    .CLK(CLK), .RST(RST), .TRST_N(TRST_N), .TMS(tms),
    .PROG_FUSE(PROG_FUSE), .SEC_FUSE(SEC_FUSE), .PIN_I(pad),
    .PIN_O(PIN_O), .PIN_OE(PIN_OE), .USER_O(USER_O), .USER_OE(USER_OE),
    .USER_I(USER_I), .PROBE_NETS(PROBE_NETS), .PROBE_OUT_A(PROBE_OUT_A),
    .PROBE_OUT_B(PROBE_OUT_B), .TRST_PU(TRST_PU), .TMS_PU(TMS_PU),
    .TDI_PU(TDI_PU), .TEST_ACTIVE(TEST_ACTIVE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR)
  );

  jpc_tester u_jpc_tester (
    .clk(CLK), .tdo(pad[2]), .tck(tck), .tms(tms), .tdi(tdi)
  );

  // ==========================================================
  // Shared helpers
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // Values read right after the edge are those sampled at it
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("[FAIL] apb ready expected 1 seen 0");
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic reg_chk(input string what, input logic [11:0] a,
                         input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    check(what, rd & m, exp);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check("trst_pu", TRST_PU, 1'b1);
    check("tms_tdi_pu", {TMS_PU, TDI_PU}, 2'h0);
    check("test_active", TEST_ACTIVE, 1'b0);
    reg_chk("status", jpc_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'hF00);
    reg_chk("ctrl rst", jpc_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h1);
  endtask

  task automatic t_user();
    USER_O <= 3'h4;
    USER_OE <= 3'h4;
    u_jpc_tester.step(1'b1, 1'b1);
    tick(4);
    check("ignored rise", TEST_ACTIVE, 1'b0);
    check("user_i", USER_I, 3'h7);
    check("pin_oe user", PIN_OE, 3'h4);
    reg_chk("state reset", jpc_pkg::ADDR_STATUS, 32'hFF, 32'h00);
  endtask

  task automatic t_capture();
    u_jpc_tester.capture();
    tick(2);
    check("captured", TEST_ACTIVE, 1'b1);
    check("user_i test", USER_I, 3'h0);
    reg_chk("idle", jpc_pkg::ADDR_STATUS, 32'hFF, 32'h12);
    u_jpc_tester.to_shift_ir();
    check("tdo drive", PIN_OE, 3'h4);
    u_jpc_tester.step(1'b1, 1'b0);
    check("tdo first", u_jpc_tester.tdo_seen, 1'b1);
    repeat (3) u_jpc_tester.step(1'b1, 1'b0);
    tick(4);
    check("four high", TEST_ACTIVE, 1'b1);
    reg_chk("sel_ir", jpc_pkg::ADDR_STATUS, 32'hFF, 32'h92);
    u_jpc_tester.step(1'b1, 1'b0);
    tick(4);
    check("released", TEST_ACTIVE, 1'b0);
    check("pin_oe back", PIN_OE, 3'h4);
  endtask

  task automatic t_trst();
    u_jpc_tester.capture();
    tick(2);
    TRST_N <= 1'b0;
    tick(6);
    check("trst release", TEST_ACTIVE, 1'b0);
    reg_chk("trst state", jpc_pkg::ADDR_STATUS, 32'hFF, 32'h00);
    TRST_N <= 1'b1;
    tick(4);
  endtask

  task automatic t_probe();
    logic [31:0] rd;
    logic        er;
    PROBE_NETS <= 16'h0408;
    u_jpc_tester.capture();
    u_jpc_tester.to_shift_ir();
    u_jpc_tester.shift4(jpc_pkg::IR_PROBE);
    u_jpc_tester.step(1'b1, 1'b0);
    u_jpc_tester.step(1'b1, 1'b0);
    u_jpc_tester.step(1'b0, 1'b0);
    u_jpc_tester.step(1'b0, 1'b0);
    u_jpc_tester.shift8(8'hA3);
    u_jpc_tester.step(1'b1, 1'b0);
    u_jpc_tester.step(1'b0, 1'b0);
    tick(4);
    reg_chk("ir", jpc_pkg::ADDR_STATUS, 32'hF00, 32'h100);
    reg_chk("selection", jpc_pkg::ADDR_PROBE, 32'hFF, 32'hA3);
    check("probes", {PROBE_OUT_A, PROBE_OUT_B}, 2'h3);
    PROBE_NETS <= 16'h0400;
    tick(3);
    check("probes b", {PROBE_OUT_A, PROBE_OUT_B}, 2'h1);
    apb(1'b1, jpc_pkg::ADDR_CTRL, 32'h0, rd, er);
    tick(3);
    check("probe off", {PROBE_OUT_A, PROBE_OUT_B}, 2'h0);
    reg_chk("ctrl off", jpc_pkg::ADDR_CTRL, 32'h1, 32'h0);
    apb(1'b1, jpc_pkg::ADDR_CTRL, 32'h1, rd, er);
    tick(3);
    check("probe on", {PROBE_OUT_A, PROBE_OUT_B}, 2'h1);
    SEC_FUSE <= 1'b1;
    tick(6);
    check("secured", {PROBE_OUT_A, PROBE_OUT_B}, 2'h0);
    reg_chk("sec bit", jpc_pkg::ADDR_STATUS, 32'h4, 32'h4);
    u_jpc_tester.release_pins();
    tick(4);
  endtask

  task automatic t_unmapped();
    logic [31:0] rd;
    logic        er;
    apb(1'b0, 12'h00C, 32'h0, rd, er);
    check("slverr", er, 1'b1);
    check("rdata", rd, 32'h0);
  endtask

  task automatic t_dedicated();
    PROG_FUSE <= 1'b1;
    tick(6);
    check("pullups", {TMS_PU, TDI_PU}, 2'h3);
    check("dedicated", TEST_ACTIVE, 1'b1);
    check("no user", USER_I, 3'h0);
    u_jpc_tester.step(1'b0, 1'b0);
    u_jpc_tester.to_shift_ir();
    check("shift tdo", PIN_OE, 3'h4);
    reg_chk("shift_ir", jpc_pkg::ADDR_STATUS, 32'hFF, 32'hB5);
    u_jpc_tester.release_pins();
    tick(6);
    check("still test", TEST_ACTIVE, 1'b1);
    reg_chk("ded reset", jpc_pkg::ADDR_STATUS, 32'hFF, 32'h05);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    tick(16);
    RST <= 1'b0;
    tick(4);
    t_reset();
    t_user();
    t_capture();
    t_trst();
    t_probe();
    t_unmapped();
    t_dedicated();
    finish_test();
  end

  initial begin
    #300000;
    errors++;
    $display("[FAIL] watchdog expected done seen hang");
    finish_test();
  end
endmodule

`default_nettype wire
